/* rtl/smg_stop_ctrl.sv */
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module smg_stop_ctrl
   import smg_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     stop_exec,
   input  wire logic                     debug_mode_enable,
   input  wire logic                     wake_irq,
   input  wire logic                     wake_pin,
   input  wire logic                     rtc_wake,
   output logic                          periph_clk_en,
   output logic                          debug_clk_en,
   output logic                          io_hold,
   output logic                          illegal_reset,
   output logic                          deep_wake_reset,
   output logic [1:0]                    stop_mode,
   output logic [2*SMG_N_UNITS-1:0]      unit_power,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [SMG_AW-1:0]        s_axi_awaddr,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   output logic [1:0]                    s_axi_bresp,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   input  wire logic [SMG_AW-1:0]        s_axi_araddr,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp
);

   smg_mode_type                  mode_reg;
   smg_mode_type                  mode_next;
   logic [SMG_CFG_W-1:0]          cfg_reg;
   logic [SMG_CFG_W-1:0]          snap_reg;
   logic                          snap_dbg_reg;
   logic                          recov_reg;
   logic                          illegal_reg;
   logic                          dwake_reg;
   smg_pwr_type [SMG_N_UNITS-1:0] units_next;
   smg_pwr_type [SMG_N_UNITS-1:0] units_reg;
   logic                          aw_hold_reg;
   logic                          w_hold_reg;
   logic [SMG_AW-1:0]             aw_addr_reg;
   logic [31:0]                   w_data_reg;
   logic [3:0]                    w_strb_reg;
   logic                          bvalid_reg;
   logic [1:0]                    bresp_reg;
   logic                          rvalid_reg;
   logic [31:0]                   rdata_reg;
   logic [1:0]                    rresp_reg;
   logic                          wr_fire;
   logic                          stop_req;
   logic                          stop_go;
   logic                          choose_deep;
   logic [31:0]                   wmask;
   logic [31:0]                   cfg_wide;
   logic [31:0]                   status_word;

   // ----------------------------------------------------------------
   // Stop mode selection
   // ----------------------------------------------------------------
   assign stop_req    = (mode_reg == SMG_RUN) && stop_exec;
   assign stop_go     = stop_req && cfg_reg[SMG_CFG_STOPEN];
   // Debug or low-voltage stop enable veto the deep state
   assign choose_deep = cfg_reg[SMG_CFG_PPD] && !debug_mode_enable
                        && !cfg_reg[SMG_CFG_LVSE];

   always_comb
   begin
      mode_next = mode_reg;
      unique case (mode_reg)
         SMG_RUN:
         begin
            if (stop_go)
            begin
               mode_next = choose_deep ? SMG_DEEP : SMG_LIGHT;
            end
         end
         SMG_LIGHT:
         begin
            if (wake_irq || wake_pin)
            begin
               mode_next = SMG_RUN;
            end
         end
         SMG_DEEP:
         begin
            if (wake_pin || (rtc_wake && snap_reg[SMG_CFG_RTC]))
            begin
               mode_next = SMG_RUN;
            end
         end
         default:
         begin
            mode_next = SMG_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_reg <= SMG_RUN;
      else
         mode_reg <= mode_next;
   end

   // Entry conditions are frozen; later config writes do not move units
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         snap_reg     <= SMG_CFG_RESET;
         snap_dbg_reg <= 1'b0;
      end
      else if (stop_go)
      begin
         snap_reg     <= cfg_reg;
         snap_dbg_reg <= debug_mode_enable;
      end
   end

   // ----------------------------------------------------------------
   // Reset requests and deep-stop recovery flag
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         illegal_reg <= 1'b0;
         dwake_reg   <= 1'b0;
      end
      else
      begin
         illegal_reg <= stop_req && !cfg_reg[SMG_CFG_STOPEN];
         dwake_reg   <= (mode_reg == SMG_DEEP) && (mode_next == SMG_RUN);
      end
   end

   // Set wins over a same-cycle clear so a wake is never missed
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         recov_reg <= 1'b0;
      else if ((mode_reg == SMG_DEEP) && (mode_next == SMG_RUN))
         recov_reg <= 1'b1;
      else if (wr_fire && (aw_addr_reg == SMG_ADDR_STATUS)
               && w_strb_reg[0] && w_data_reg[SMG_STAT_RECOV])
         recov_reg <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Unit power and clock gating
   // ----------------------------------------------------------------
   smg_policy u_policy
   (
      .mode   (mode_reg),
      .dbg    (snap_dbg_reg),
      .lv_on  (snap_reg[SMG_CFG_LVEN] && snap_reg[SMG_CFG_LVSE]),
      .cfg    (snap_reg),
      .units  (units_next)
   );

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         units_reg <= '{default: SMG_PWR_ON};
      else
         units_reg <= units_next;
   end

   assign unit_power      = units_reg;
   assign stop_mode       = mode_reg;
   assign periph_clk_en   = (mode_reg == SMG_RUN);
   assign debug_clk_en    = (mode_reg == SMG_RUN)
                            || ((mode_reg == SMG_LIGHT) && snap_dbg_reg);
   // Pins stay latched after deep wake until software acknowledges
   assign io_hold         = (mode_reg != SMG_RUN) || recov_reg;
   assign illegal_reset   = illegal_reg;
   assign deep_wake_reset = dwake_reg;

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready  = !w_hold_reg;
   assign wr_fire       = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wmask         = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                           {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   assign cfg_wide      = {{(32-SMG_CFG_W){1'b0}}, cfg_reg};

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_hold_reg  <= 1'b0;
         w_data_reg  <= 32'h0;
         w_strb_reg  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && !aw_hold_reg)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_hold_reg <= 1'b0;
         if (s_axi_wvalid && !w_hold_reg)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         cfg_reg <= SMG_CFG_RESET;
      else if (wr_fire && (aw_addr_reg == SMG_ADDR_CONFIG))
         cfg_reg <= SMG_CFG_W'((cfg_wide & ~wmask) | (w_data_reg & wmask));
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= SMG_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= ((aw_addr_reg == SMG_ADDR_CONFIG) || (aw_addr_reg == SMG_ADDR_STATUS))
                       ? SMG_RESP_OKAY : SMG_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   assign status_word   = {28'h0, snap_dbg_reg, recov_reg, mode_reg};
   assign s_axi_arready = !rvalid_reg;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0;
         rresp_reg  <= SMG_RESP_OKAY;
      end
      else if (s_axi_arvalid && !rvalid_reg)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= SMG_RESP_OKAY;
         unique case (s_axi_araddr)
            SMG_ADDR_CONFIG: rdata_reg <= cfg_wide;
            SMG_ADDR_STATUS: rdata_reg <= status_word;
            SMG_ADDR_UNITS:  rdata_reg <= {6'h0, units_reg};
            default:
            begin
               rdata_reg <= 32'h0;
               rresp_reg <= SMG_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   periph_gate_a: assert property (stop_go |=> !periph_clk_en && io_hold)
      else $error("peripheral clock running in stop");
   debug_clock_a: assert property (stop_go && debug_mode_enable
      |=> debug_clk_en && (mode_reg == SMG_LIGHT))
      else $error("debug clock not kept in stop");
   debug_light_a: assert property (stop_go && cfg_reg[SMG_CFG_PPD] && debug_mode_enable
      |=> mode_reg == SMG_LIGHT)
      else $error("debug enable did not force light stop");
   lowvolt_light_a: assert property (stop_go && cfg_reg[SMG_CFG_LVSE]
      |=> mode_reg == SMG_LIGHT)
      else $error("low-voltage stop enable did not force light stop");
   regulator_on_a: assert property (mode_reg == SMG_LIGHT
      && $past(mode_reg) == SMG_LIGHT
      |-> (units_reg[SMG_U_REG] == SMG_PWR_ON) == (snap_dbg_reg
          || (snap_reg[SMG_CFG_LVEN] && snap_reg[SMG_CFG_LVSE])))
      else $error("regulator state wrong in light stop");
   converter_run_a: assert property (mode_reg == SMG_LIGHT
      && $past(mode_reg) == SMG_LIGHT && !snap_reg[SMG_CFG_CONVCLK]
      |-> units_reg[SMG_U_CONV] == SMG_PWR_STBY)
      else $error("converter running without its clock");
   deep_off_a: assert property (mode_reg == SMG_DEEP ##1 mode_reg == SMG_DEEP
      |-> units_reg[SMG_U_CPU] == SMG_PWR_OFF && units_reg[SMG_U_RAM] == SMG_PWR_STBY)
      else $error("deep stop unit power wrong");
   pin_hold_a: assert property ($fell(mode_reg == SMG_DEEP)
      |-> io_hold && deep_wake_reset)
      else $error("pins released on deep wake");
   illegal_stop_a: assert property (stop_req && !cfg_reg[SMG_CFG_STOPEN]
      |=> illegal_reset && mode_reg == SMG_RUN ##1 !illegal_reset)
      else $error("disabled stop not turned into reset");
   deep_choice_a: assert property (stop_go && !debug_mode_enable
      && !cfg_reg[SMG_CFG_LVSE]
      |=> mode_reg == ($past(cfg_reg[SMG_CFG_PPD]) ? SMG_DEEP : SMG_LIGHT))
      else $error("stop state choice wrong");

endmodule
`default_nettype wire

/* common/smg_pkg.sv */
package smg_pkg;

   // ----------------------------------------------------------------
   // Modes and unit power codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      SMG_RUN   = 2'b00,
      SMG_LIGHT = 2'b01,
      SMG_DEEP  = 2'b10
   } smg_mode_type;

   typedef enum logic [1:0]
   {
      SMG_PWR_OFF  = 2'b00,
      SMG_PWR_STBY = 2'b01,
      SMG_PWR_ON   = 2'b10
   } smg_pwr_type;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          SMG_AW          = 8;
   localparam logic [7:0]  SMG_ADDR_CONFIG = 8'h00;
   localparam logic [7:0]  SMG_ADDR_STATUS = 8'h04;
   localparam logic [7:0]  SMG_ADDR_UNITS  = 8'h08;
   localparam logic [1:0]  SMG_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  SMG_RESP_SLVERR = 2'h2;

   // Configuration register fields
   localparam int          SMG_CFG_W        = 13;
   localparam logic [12:0] SMG_CFG_RESET    = 13'h0000;
   localparam int          SMG_CFG_STOPEN   = 0;
   localparam int          SMG_CFG_PPD      = 1;
   localparam int          SMG_CFG_LVEN     = 2;
   localparam int          SMG_CFG_LVSE     = 3;
   localparam int          SMG_CFG_IRCLK    = 4;
   localparam int          SMG_CFG_IRSTOP   = 5;
   localparam int          SMG_CFG_ERCLK    = 6;
   localparam int          SMG_CFG_ERSTOP   = 7;
   localparam int          SMG_CFG_XHIGH    = 8;
   localparam int          SMG_CFG_CONVCLK  = 9;
   localparam int          SMG_CFG_BANDGAP  = 10;
   localparam int          SMG_CFG_RTC      = 11;
   localparam int          SMG_CFG_CMPEN    = 12;

   // Status register fields
   localparam int          SMG_STAT_RECOV   = 2;
   localparam int          SMG_STAT_DBG     = 3;

   // ----------------------------------------------------------------
   // Unit indices
   // ----------------------------------------------------------------
   localparam int SMG_N_UNITS = 13;
   localparam int SMG_U_CPU   = 0;
   localparam int SMG_U_RAM   = 1;
   localparam int SMG_U_FLASH = 2;
   localparam int SMG_U_PORT  = 3;
   localparam int SMG_U_CONV  = 4;
   localparam int SMG_U_CMP   = 5;
   localparam int SMG_U_DBG   = 6;
   localparam int SMG_U_CLKS  = 7;
   localparam int SMG_U_VDET  = 8;
   localparam int SMG_U_REG   = 9;
   localparam int SMG_U_XTAL  = 10;
   localparam int SMG_U_RTC   = 11;
   localparam int SMG_U_PERI  = 12;

endpackage

/* rtl/smg_policy.sv */
`timescale 1ns/1ps
`default_nettype none

module smg_policy
   import smg_pkg::*;
(
   input  wire smg_mode_type                        mode,
   input  wire logic                                dbg,
   input  wire logic                                lv_on,
   input  wire logic [SMG_CFG_W-1:0]                cfg,
   output smg_pwr_type [SMG_N_UNITS-1:0]            units
);

   // ----------------------------------------------------------------
   // Per-unit power decision
   // ----------------------------------------------------------------
   always_comb
   begin
      units = '{default: SMG_PWR_ON};
      unique case (mode)
         SMG_RUN:
         begin
            units = '{default: SMG_PWR_ON};
         end
         SMG_LIGHT:
         begin
            units = '{default: SMG_PWR_STBY};
            units[SMG_U_CONV] = (cfg[SMG_CFG_CONVCLK] && lv_on) ?
                                SMG_PWR_ON : SMG_PWR_STBY;
            // Bandgap compare needs the detector supply kept up
            units[SMG_U_CMP]  = (cfg[SMG_CFG_CMPEN] && (!cfg[SMG_CFG_BANDGAP] || lv_on)) ?
                                SMG_PWR_ON : SMG_PWR_STBY;
            units[SMG_U_DBG]  = dbg ? SMG_PWR_ON : SMG_PWR_STBY;
            units[SMG_U_CLKS] = (cfg[SMG_CFG_IRCLK] && cfg[SMG_CFG_IRSTOP]) ?
                                SMG_PWR_ON : SMG_PWR_STBY;
            units[SMG_U_VDET] = lv_on ? SMG_PWR_ON : SMG_PWR_OFF;
            units[SMG_U_REG]  = (dbg || lv_on) ? SMG_PWR_ON : SMG_PWR_STBY;
            units[SMG_U_XTAL] = (cfg[SMG_CFG_ERCLK] && cfg[SMG_CFG_ERSTOP] &&
                                 (!cfg[SMG_CFG_XHIGH] || lv_on)) ?
                                SMG_PWR_ON : SMG_PWR_STBY;
            units[SMG_U_RTC]  = cfg[SMG_CFG_RTC] ? SMG_PWR_ON : SMG_PWR_OFF;
         end
         SMG_DEEP:
         begin
            units = '{default: SMG_PWR_OFF};
            units[SMG_U_RAM] = SMG_PWR_STBY;
            units[SMG_U_REG] = SMG_PWR_STBY;
            units[SMG_U_RTC] = cfg[SMG_CFG_RTC] ? SMG_PWR_ON : SMG_PWR_OFF;
         end
         default:
         begin
            units = '{default: SMG_PWR_ON};
         end
      endcase
   end

endmodule
`default_nettype wire

/* verification/smg_stop_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module smg_stop_ctrl_tb
   import smg_pkg::*;
();

   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic                         sys_clk           = 1'b0;
   logic                         rst_n             = 1'b0;
   logic                         stop_exec         = 1'b0;
   logic                         debug_mode_enable = 1'b0;
   logic                         wake_irq          = 1'b0;
   logic                         wake_pin          = 1'b0;
   logic                         rtc_wake          = 1'b0;
   logic                         s_axi_awvalid     = 1'b0;
   logic [SMG_AW-1:0]            s_axi_awaddr      = '0;
   logic                         s_axi_wvalid      = 1'b0;
   logic [31:0]                  s_axi_wdata       = '0;
   logic [3:0]                   s_axi_wstrb       = 4'hf;
   logic                         s_axi_bready      = 1'b0;
   logic                         s_axi_arvalid     = 1'b0;
   logic [SMG_AW-1:0]            s_axi_araddr      = '0;
   logic                         s_axi_rready      = 1'b0;
   logic                         periph_clk_en;
   logic                         debug_clk_en;
   logic                         io_hold;
   logic                         illegal_reset;
   logic                         deep_wake_reset;
   logic [1:0]                   stop_mode;
   logic [2*SMG_N_UNITS-1:0]     unit_power;
   logic                         s_axi_awready;
   logic                         s_axi_wready;
   logic                         s_axi_bvalid;
   logic [1:0]                   s_axi_bresp;
   logic                         s_axi_arready;
   logic                         s_axi_rvalid;
   logic [31:0]                  s_axi_rdata;
   logic [1:0]                   s_axi_rresp;
   int                           mismatches        = 0;
   int                           n_compared        = 0;
   int                           n_ill             = 0;
   int                           n_dwr             = 0;
   // Bit 13 carries the debug enable, the rest the configuration word
   localparam logic [13:0] CASES [8] = '{14'h0803, 14'h2003, 14'h000b, 14'h0001,
                                         14'h1ffd, 14'h1ff9, 14'h10f1, 14'h0053};

   always #5 sys_clk = ~sys_clk;

   smg_stop_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .stop_exec(stop_exec),
      .debug_mode_enable(debug_mode_enable), .wake_irq(wake_irq), .wake_pin(wake_pin),
      .rtc_wake(rtc_wake), .periph_clk_en(periph_clk_en), .debug_clk_en(debug_clk_en),
      .io_hold(io_hold), .illegal_reset(illegal_reset), .deep_wake_reset(deep_wake_reset),
      .stop_mode(stop_mode), .unit_power(unit_power), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

   // Pulses last one cycle, so count them rather than hunt for the cycle
   always @(posedge sys_clk)
   begin
      if (illegal_reset === 1'b1)
         n_ill <= n_ill + 1;
      if (deep_wake_reset === 1'b1)
         n_dwr <= n_dwr + 1;
   end

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      logic aw_go;
      logic w_go;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(negedge sys_clk);
         aw_go = s_axi_awvalid && s_axi_awready;
         w_go  = s_axi_wvalid && s_axi_wready;
         @(posedge sys_clk);
         if (aw_go)
            s_axi_awvalid <= 1'b0;
         if (w_go)
            s_axi_wvalid <= 1'b0;
         aw_ok = aw_ok | aw_go;
         w_ok  = w_ok | w_go;
      end
      s_axi_bready <= 1'b1;
      do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      @(posedge sys_clk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      s_axi_rready <= 1'b0;
   endtask

   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      axi_wr(a, d, r);
      check("bresp", 32'(er), 32'(r));
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      check("rdata", ed, d);
      check("rresp", 32'(er), 32'(r));
   endtask

   // Kind: 0 stop, 1 interrupt wake, 2 wake pin, 3 counter wake
   task automatic pulse(input int k);
      @(posedge sys_clk);
      case (k)
         0: stop_exec <= 1'b1;
         1: wake_irq <= 1'b1;
         2: wake_pin <= 1'b1;
         default: rtc_wake <= 1'b1;
      endcase
      @(posedge sys_clk);
      {stop_exec, wake_irq, wake_pin, rtc_wake} <= 4'h0;
   endtask

   // ----------------------------------------------------------------
   // Expected unit power per stop state
   // ----------------------------------------------------------------
   function automatic logic [25:0] exp_units(input logic [1:0] m, input logic dg,
                                             input logic [12:0] c);
      smg_pwr_type u [SMG_N_UNITS];
      logic        lv;
      logic [25:0] v;
      lv = c[SMG_CFG_LVEN] & c[SMG_CFG_LVSE];
      for (int i = 0; i < SMG_N_UNITS; i++)
         u[i] = (m == SMG_RUN) ? SMG_PWR_ON : (m == SMG_DEEP) ? SMG_PWR_OFF : SMG_PWR_STBY;
      if (m == SMG_DEEP)
      begin
         u[SMG_U_RAM] = SMG_PWR_STBY;
         u[SMG_U_REG] = SMG_PWR_STBY;
      end
      if (m == SMG_LIGHT)
      begin
         u[SMG_U_CONV] = (c[SMG_CFG_CONVCLK] && lv) ? SMG_PWR_ON : SMG_PWR_STBY;
         u[SMG_U_CMP]  = (c[SMG_CFG_CMPEN] && (!c[SMG_CFG_BANDGAP] || lv)) ? SMG_PWR_ON
                         : SMG_PWR_STBY;
         u[SMG_U_DBG]  = dg ? SMG_PWR_ON : SMG_PWR_STBY;
         u[SMG_U_CLKS] = (c[SMG_CFG_IRCLK] && c[SMG_CFG_IRSTOP]) ? SMG_PWR_ON
                         : SMG_PWR_STBY;
         u[SMG_U_VDET] = lv ? SMG_PWR_ON : SMG_PWR_OFF;
         u[SMG_U_REG]  = (dg || lv) ? SMG_PWR_ON : SMG_PWR_STBY;
         u[SMG_U_XTAL] = (c[SMG_CFG_ERCLK] && c[SMG_CFG_ERSTOP] && (!c[SMG_CFG_XHIGH] || lv))
                         ? SMG_PWR_ON : SMG_PWR_STBY;
      end
      if (m != SMG_RUN)
         u[SMG_U_RTC] = c[SMG_CFG_RTC] ? SMG_PWR_ON : SMG_PWR_OFF;
      for (int i = 0; i < SMG_N_UNITS; i++)
         v[2*i +: 2] = u[i];
      return v;
   endfunction

   // ----------------------------------------------------------------
   // One stop entry and wake-up
   // ----------------------------------------------------------------
   task automatic run_stop(input logic [12:0] c, input logic dg);
      logic [1:0] m;
      int         dw;
      m = (c[SMG_CFG_PPD] && !dg && !c[SMG_CFG_LVSE]) ? SMG_DEEP : SMG_LIGHT;
      wr_chk(SMG_ADDR_CONFIG, {19'h0, c}, SMG_RESP_OKAY);
      rd_chk(SMG_ADDR_CONFIG, {19'h0, c}, SMG_RESP_OKAY);
      debug_mode_enable <= dg;
      dw = n_dwr;
      pulse(0);
      @(posedge sys_clk);
      @(negedge sys_clk);
      check("stop_mode", 32'(m), 32'(stop_mode));
      check("periph_clk_en", 32'h0, 32'(periph_clk_en));
      check("debug_clk_en", 32'(m == SMG_LIGHT && dg), 32'(debug_clk_en));
      check("io_hold", 32'h1, 32'(io_hold));
      check("unit_power", 32'(exp_units(m, dg, c)), 32'(unit_power));
      rd_chk(SMG_ADDR_STATUS, {28'h0, dg, 1'b0, m}, SMG_RESP_OKAY);
      rd_chk(SMG_ADDR_UNITS, {6'h0, exp_units(m, dg, c)}, SMG_RESP_OKAY);
      // Deep stop only leaves on the pin or on an enabled counter
      pulse(m == SMG_DEEP ? (c[SMG_CFG_RTC] ? 3 : 2) : 1);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      check("stop_mode", 32'(SMG_RUN), 32'(stop_mode));
      check("periph_clk_en", 32'h1, 32'(periph_clk_en));
      check("deep_wake_reset", 32'(m == SMG_DEEP), 32'(n_dwr - dw));
      if (m == SMG_DEEP)
      begin
         check("io_hold", 32'h1, 32'(io_hold));
         rd_chk(SMG_ADDR_STATUS, 32'h4, SMG_RESP_OKAY);
         wr_chk(SMG_ADDR_STATUS, 32'h4, SMG_RESP_OKAY);
         @(negedge sys_clk);
         check("io_hold", 32'h0, 32'(io_hold));
      end
   endtask

   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      check("stop_mode", 32'(SMG_RUN), 32'(stop_mode));
      check("periph_clk_en", 32'h1, 32'(periph_clk_en));
      check("unit_power", 32'h2aaaaaa, 32'(unit_power));
      rd_chk(SMG_ADDR_CONFIG, 32'h0, SMG_RESP_OKAY);
      rd_chk(SMG_ADDR_UNITS, 32'h2aaaaaa, SMG_RESP_OKAY);
      rd_chk(8'h10, 32'h0, SMG_RESP_SLVERR);
      wr_chk(SMG_ADDR_UNITS, 32'hffffffff, SMG_RESP_SLVERR);
      wr_chk(8'h3c, 32'h1, SMG_RESP_SLVERR);
      rd_chk(SMG_ADDR_CONFIG, 32'h0, SMG_RESP_OKAY);
      // Stop with the enable clear must not leave run
      pulse(0);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      check("illegal_reset", 32'h1, 32'(n_ill));
      check("stop_mode", 32'(SMG_RUN), 32'(stop_mode));
      check("periph_clk_en", 32'h1, 32'(periph_clk_en));
      foreach (CASES[i])
         run_stop(CASES[i][12:0], CASES[i][13]);
      summarize;
   end

   // Whole run needs a few hundred cycles; this is far beyond it
   initial
   begin
      #300us;
      mismatches++;
      summarize;
   end

endmodule

`default_nettype wire
